/* File: core/pmpr_pkg.sv */
// constants, register map and encodings for the pointer map and power-down block
// assumes a single 250 MHz system clock and an I2C controller on the far pins
package pmpr_pkg;

  // ==========================================================
  // pointer modes (upper nibble of the pointer byte)
  localparam logic [3:0] MODE_CONFIG = 4'h0;
  localparam logic [3:0] MODE_DAC_WRITE = 4'h1;
  localparam logic [3:0] MODE_ADC_READ = 4'h2;
  localparam logic [3:0] MODE_DAC_READ = 4'h3;
  localparam logic [3:0] MODE_GPIO_READ = 4'h4;
  localparam logic [3:0] MODE_REG_READ = 4'h5;

  // ==========================================================
  // control register offsets (lower nibble in configuration mode)
  localparam logic [3:0] OFS_NO_OPERATION = 4'h0;
  localparam logic [3:0] OFS_CONVERSION_SEQUENCE = 4'h2;
  localparam logic [3:0] OFS_GENERAL_CONTROL = 4'h3;
  localparam logic [3:0] OFS_ANALOG_INPUT_PIN_SELECT = 4'h4;
  localparam logic [3:0] OFS_ANALOG_OUTPUT_PIN_SELECT = 4'h5;
  localparam logic [3:0] OFS_PULLDOWN_SELECT = 4'h6;
  localparam logic [3:0] OFS_LOAD_MODE = 4'h7;
  localparam logic [3:0] OFS_DIGITAL_OUTPUT_SELECT = 4'h8;
  localparam logic [3:0] OFS_DIGITAL_OUTPUT_VALUE = 4'h9;
  localparam logic [3:0] OFS_DIGITAL_INPUT_SELECT = 4'hA;
  localparam logic [3:0] OFS_POWERDOWN_REFERENCE_CONTROL = 4'hB;
  localparam logic [3:0] OFS_DRAIN_MODE_SELECT = 4'hC;
  localparam logic [3:0] OFS_HIGH_IMPEDANCE_SELECT = 4'hD;
  localparam logic [3:0] OFS_SOFT_RESTART = 4'hF;

  // ==========================================================
  // reset values and magic words
  localparam logic [15:0] RST_DEFAULT = 16'h0000;
  localparam logic [15:0] RST_PULLDOWN_SELECT = 16'h00FF;
  localparam logic [15:0] SOFT_RESTART_KEY = 16'h0DAC;

  // ==========================================================
  // field positions
  localparam int GLOBAL_POWERDOWN_BIT = 10;
  localparam int REF_ENABLE_BIT = 9;
  localparam int TEMP_READ_BIT = 8;
  localparam int DAC_CODE_WIDTH = 12;

  // ==========================================================
  // timing: reset completion time, longest figure so rounded down
  localparam int RESET_TIME_US = 100;
  localparam int CLK_MHZ = 250;
  localparam int RESET_CYCLES = RESET_TIME_US * CLK_MHZ;

  // bus engine states, gray along start-byte-ack-byte path
  typedef enum logic [2:0] {
    PMPR_IDLE = 3'b000,
    PMPR_RX = 3'b001,
    PMPR_RX_ACK = 3'b011,
    PMPR_TX = 3'b010,
    PMPR_TX_ACK = 3'b110
  } pmpr_state_e;

endpackage

/* File: core/pmpr_core.sv */
// pointer decode, control registers, power-down control and resets, with the I2C target
// assumes scl/sda/reset pins arrive asynchronously; sda is open-drain outside
`timescale 1ns/1ps

module pmpr_core #(
  parameter logic [6:0] DEV_ADDR = 7'h10,            // bus address, arbitrary default
  parameter int RESET_CYCLES = pmpr_pkg::RESET_CYCLES // shorten in simulation
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic scl_in,                // I2C clock pin level
  input wire logic sda_in,                // I2C data pin level
  output logic sda_out,                   // always low; pin is open-drain
  output logic sda_oe,                    // high while pulling sda low
  input wire logic reset_pin_n,           // hardware reset pin, active low
  input wire logic [15:0] adc_result,     // latest conversion word from the converter
  input wire logic [7:0] gpio_level,      // digital input levels from the pin logic
  output logic [95:0] dac_code,           // eight 12-bit held DAC codes, channel 0 low
  output logic [7:0] dac_powerdown,       // per channel powered down
  output logic [7:0] dac_hiz,             // per channel analog output high impedance
  output logic ref_enable,                // reference and buffer powered
  output logic adc_power,                 // converter powered
  output logic [15:0] conversion_sequence,
  output logic [15:0] general_control,
  output logic [7:0] analog_input_pins,
  output logic [7:0] analog_output_pins,
  output logic [7:0] pulldown_pins,
  output logic [15:0] load_mode,
  output logic [7:0] digital_output_pins,
  output logic [7:0] digital_output_value,
  output logic [7:0] digital_input_pins,
  output logic [7:0] drain_mode_pins,
  output logic [7:0] high_impedance_pins,
  output logic restart_busy               // reset action in progress, bus ignored
);

  // ==========================================================
  // pin synchronisers: three stages, a level counts once stages two and three agree
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [2:0] rpin_sync;
  logic scl_f;                            // filtered clock level
  logic sda_f;                            // filtered data level
  logic rpin_f;                           // filtered reset pin level
  logic scl_q;                            // previous filtered clock
  logic sda_q;                            // previous filtered data
  logic rpin_q;                           // previous filtered reset pin

  // shift chains; stage 0 is only read by stage 1
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      rpin_sync <= 3'h7;
    end else begin
      scl_sync <= {scl_sync[1:0], scl_in};
      sda_sync <= {sda_sync[1:0], sda_in};
      rpin_sync <= {rpin_sync[1:0], reset_pin_n};
    end
  end

  // filtered levels only move when the last two stages agree
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      rpin_f <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      rpin_q <= 1'b1;
    end else begin
      if (scl_sync[1] == scl_sync[2]) scl_f <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2]) sda_f <= sda_sync[2];
      if (rpin_sync[1] == rpin_sync[2]) rpin_f <= rpin_sync[2];
      scl_q <= scl_f;
      sda_q <= sda_f;
      rpin_q <= rpin_f;
    end
  end

  // bus events
  wire scl_rise = scl_f & ~scl_q;
  wire scl_fall = ~scl_f & scl_q;
  wire bus_start = scl_f & scl_q & sda_q & ~sda_f;
  wire bus_stop = scl_f & scl_q & ~sda_q & sda_f;
  wire pin_reset_edge = rpin_q & ~rpin_f;

  // ==========================================================
  // byte engine state
  pmpr_pkg::pmpr_state_e state;
  pmpr_pkg::pmpr_state_e next_state;
  logic [7:0] shreg;                      // receive shift register
  logic [3:0] bit_cnt;                    // bits taken in the current byte
  logic [1:0] byte_idx;                   // 0 address, 1 pointer, 2 msb, 3 lsb
  logic rd_mode;                          // transfer is a read
  logic [7:0] pointer;                    // last pointer byte written
  logic [7:0] msb_hold;                   // first data byte of a word
  logic [15:0] tx_word;                   // word being sent on a read
  logic tx_lsb;                           // sending the low byte
  logic ack_drive;                        // pull sda low for the ack slot
  logic [15:0] regs [0:15];               // control registers by offset
  logic [11:0] dac_hold [0:7];            // held DAC codes
  logic [14:0] busy_cnt;                  // reset completion counter

  // ==========================================================
  // byte decode
  wire byte_done = scl_fall & (state == pmpr_pkg::PMPR_RX) & (bit_cnt == 4'h8);
  wire addr_hit = (shreg[7:1] == DEV_ADDR);
  wire [3:0] ptr_mode = pointer[7:4];
  wire [3:0] ptr_sel = pointer[3:0];
  wire [2:0] ptr_chan = pointer[2:0];
  wire [15:0] rx_word = {msb_hold, shreg};
  wire mode_cfg = (ptr_mode == pmpr_pkg::MODE_CONFIG);
  wire cfg_reg_ok = mode_cfg & (ptr_sel >= pmpr_pkg::OFS_CONVERSION_SEQUENCE)
                    & (ptr_sel <= pmpr_pkg::OFS_HIGH_IMPEDANCE_SELECT);
  wire soft_key = mode_cfg & (ptr_sel == pmpr_pkg::OFS_SOFT_RESTART)
                  & (rx_word == pmpr_pkg::SOFT_RESTART_KEY);
  wire lsb_done = byte_done & ~rd_mode & (byte_idx == 2'h3);
  wire soft_restart = lsb_done & soft_key;
  wire cfg_write = lsb_done & cfg_reg_ok;
  wire dac_write = lsb_done & (ptr_mode == pmpr_pkg::MODE_DAC_WRITE);
  wire do_reset = soft_restart | pin_reset_edge;
  wire busy = (busy_cnt != 15'h0000);

  // readback word chosen by pointer mode; undefined modes read zero
  logic [15:0] rd_word;
  always_comb begin
    case (ptr_mode)
      pmpr_pkg::MODE_ADC_READ: rd_word = adc_result;
      pmpr_pkg::MODE_DAC_READ: rd_word = {1'b1, ptr_chan, dac_hold[ptr_chan]};
      pmpr_pkg::MODE_GPIO_READ: rd_word = {8'h00, gpio_level};
      pmpr_pkg::MODE_REG_READ: rd_word = regs[ptr_sel];
      default: rd_word = 16'h0000;
    endcase
  end

  // ==========================================================
  // next state of the byte engine
  always_comb begin
    next_state = state;
    case (state)
      pmpr_pkg::PMPR_IDLE: begin
        next_state = pmpr_pkg::PMPR_IDLE;
      end
      pmpr_pkg::PMPR_RX: begin
        // address miss or soft restart key: leave without acknowledging
        if (byte_done) begin
          if ((byte_idx == 2'h0 && !addr_hit) || soft_restart) next_state = pmpr_pkg::PMPR_IDLE;
          else next_state = pmpr_pkg::PMPR_RX_ACK;
        end
      end
      pmpr_pkg::PMPR_RX_ACK: begin
        if (scl_fall) next_state = rd_mode ? pmpr_pkg::PMPR_TX : pmpr_pkg::PMPR_RX;
      end
      pmpr_pkg::PMPR_TX: begin
        // the count reaches eight on this very fall, so the ack slot starts here
        if (scl_fall && bit_cnt == 4'h7) next_state = pmpr_pkg::PMPR_TX_ACK;
      end
      pmpr_pkg::PMPR_TX_ACK: begin
        // ack taken as the ack clock falls: data still holds, and the bit count never sees that fall
        if (scl_fall) next_state = sda_f ? pmpr_pkg::PMPR_IDLE : pmpr_pkg::PMPR_TX;
      end
      default: next_state = pmpr_pkg::PMPR_IDLE;
    endcase
  end

  // state register; start and stop win, reset action silences the bus
  always_ff @(posedge clk_sys) begin
    if (!rst_n || busy || do_reset) state <= pmpr_pkg::PMPR_IDLE;
    else if (bus_stop) state <= pmpr_pkg::PMPR_IDLE;
    else if (bus_start) state <= pmpr_pkg::PMPR_RX;
    else state <= next_state;
  end

  // ==========================================================
  // bit counter and receive shift register
  always_ff @(posedge clk_sys) begin
    if (!rst_n || bus_start) begin
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
    end else if (state == pmpr_pkg::PMPR_RX && scl_rise) begin
      shreg <= {shreg[6:0], sda_f};
      bit_cnt <= bit_cnt + 4'h1;
    end else if (state == pmpr_pkg::PMPR_TX && scl_fall) begin
      bit_cnt <= bit_cnt + 4'h1;
    end else if (state != pmpr_pkg::PMPR_RX && state != pmpr_pkg::PMPR_TX) begin
      bit_cnt <= 4'h0;
    end
  end

  // byte index, direction, pointer and high data byte
  always_ff @(posedge clk_sys) begin
    if (!rst_n || do_reset) begin
      byte_idx <= 2'h0;
      rd_mode <= 1'b0;
      pointer <= 8'h00;
      msb_hold <= 8'h00;
    end else if (bus_start) begin
      byte_idx <= 2'h0;
      rd_mode <= 1'b0;
    end else if (byte_done) begin
      case (byte_idx)
        2'h0: rd_mode <= shreg[0];
        2'h1: pointer <= shreg;
        2'h2: msb_hold <= shreg;
        default: msb_hold <= msb_hold;
      endcase
      // words repeat msb, lsb after the pointer
      byte_idx <= (byte_idx == 2'h3) ? 2'h2 : byte_idx + 2'h1;
    end
  end

  // ==========================================================
  // transmit side: the word is loaded when the address ack ends
  always_ff @(posedge clk_sys) begin
    if (!rst_n || bus_start) begin
      tx_word <= 16'h0000;
      tx_lsb <= 1'b0;
    end else if (state == pmpr_pkg::PMPR_RX_ACK && scl_fall && rd_mode) begin
      tx_word <= rd_word;
      tx_lsb <= 1'b0;
    end else if (state == pmpr_pkg::PMPR_TX_ACK && scl_fall && !sda_f) begin
      // next byte: low half, or a fresh word for streaming reads
      if (tx_lsb) tx_word <= rd_word;
      tx_lsb <= ~tx_lsb;
    end
  end

  wire [7:0] tx_byte = tx_lsb ? tx_word[7:0] : tx_word[15:8];
  wire [2:0] tx_bit_idx = 3'h7 - bit_cnt[2:0];

  // ack drive: set on the eighth falling edge, held through the ack clock
  always_ff @(posedge clk_sys) begin
    if (!rst_n || do_reset || bus_start || bus_stop) ack_drive <= 1'b0;
    else if (state == pmpr_pkg::PMPR_RX && next_state == pmpr_pkg::PMPR_RX_ACK) ack_drive <= 1'b1;
    else if (state == pmpr_pkg::PMPR_RX_ACK && scl_fall) ack_drive <= 1'b0;
  end

  // data pin: ack, or a zero data bit while sending; sda is open-drain
  always_ff @(posedge clk_sys) begin
    if (!rst_n) sda_oe <= 1'b0;
    else if (state == pmpr_pkg::PMPR_TX && bit_cnt < 4'h8) sda_oe <= ~tx_byte[tx_bit_idx];
    else sda_oe <= ack_drive;
  end
  assign sda_out = 1'b0;

  // ==========================================================
  // control registers, cleared by either reset; pull-downs come back on
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_regs
      localparam logic [15:0] RST_VAL = (gi == pmpr_pkg::OFS_PULLDOWN_SELECT) ?
                                        pmpr_pkg::RST_PULLDOWN_SELECT : pmpr_pkg::RST_DEFAULT;
      always_ff @(posedge clk_sys) begin
        if (!rst_n || do_reset) regs[gi] <= RST_VAL;
        else if (cfg_write && ptr_sel == 4'(gi)) regs[gi] <= rx_word;
      end
    end
    // held DAC codes: power-down never touches them, so outputs resume
    for (gi = 0; gi < 8; gi++) begin : g_dac
      always_ff @(posedge clk_sys) begin
        if (!rst_n || do_reset) dac_hold[gi] <= 12'h000;
        else if (dac_write && ptr_chan == 3'(gi)) dac_hold[gi] <= rx_word[11:0];
      end
      assign dac_code[gi*12 +: 12] = dac_hold[gi];
    end
  endgenerate

  // reset completion counter; bus is ignored until it runs out
  always_ff @(posedge clk_sys) begin
    if (!rst_n) busy_cnt <= 15'h0000;
    else if (do_reset) busy_cnt <= 15'(RESET_CYCLES);
    else if (busy) busy_cnt <= busy_cnt - 15'h0001;
  end
  assign restart_busy = busy;

  // ==========================================================
  // power-down and reference control
  wire [15:0] pdref = regs[pmpr_pkg::OFS_POWERDOWN_REFERENCE_CONTROL];
  wire global_powerdown = pdref[pmpr_pkg::GLOBAL_POWERDOWN_BIT];
  wire temp_read = regs[pmpr_pkg::OFS_CONVERSION_SEQUENCE][pmpr_pkg::TEMP_READ_BIT];
  wire any_adc_pin = |regs[pmpr_pkg::OFS_ANALOG_INPUT_PIN_SELECT][7:0];

  // individual bits only count for pins that are DAC outputs
  assign dac_powerdown = global_powerdown ? 8'hFF
                         : (pdref[7:0] & regs[pmpr_pkg::OFS_ANALOG_OUTPUT_PIN_SELECT][7:0]);
  assign dac_hiz = dac_powerdown;
  assign ref_enable = pdref[pmpr_pkg::REF_ENABLE_BIT] & ~global_powerdown;
  assign adc_power = (any_adc_pin | temp_read) & ~global_powerdown;

  // ==========================================================
  // pin configuration views
  assign conversion_sequence = regs[pmpr_pkg::OFS_CONVERSION_SEQUENCE];
  assign general_control = regs[pmpr_pkg::OFS_GENERAL_CONTROL];
  assign analog_input_pins = regs[pmpr_pkg::OFS_ANALOG_INPUT_PIN_SELECT][7:0];
  assign analog_output_pins = regs[pmpr_pkg::OFS_ANALOG_OUTPUT_PIN_SELECT][7:0];
  assign pulldown_pins = regs[pmpr_pkg::OFS_PULLDOWN_SELECT][7:0];
  assign load_mode = regs[pmpr_pkg::OFS_LOAD_MODE];
  assign digital_output_pins = regs[pmpr_pkg::OFS_DIGITAL_OUTPUT_SELECT][7:0];
  assign digital_output_value = regs[pmpr_pkg::OFS_DIGITAL_OUTPUT_VALUE][7:0];
  assign digital_input_pins = regs[pmpr_pkg::OFS_DIGITAL_INPUT_SELECT][7:0];
  assign drain_mode_pins = regs[pmpr_pkg::OFS_DRAIN_MODE_SELECT][7:0];
  assign high_impedance_pins = regs[pmpr_pkg::OFS_HIGH_IMPEDANCE_SELECT][7:0];

endmodule // pmpr_core

/* File: tb/pmpr_core_checker.sv */
// checker: power-down, restart and default relations seen at the core ports
// assumes a bind onto pmpr_core, one clock, synchronous active-low reset
`timescale 1ns/1ps
module pmpr_core_checker #(
  parameter int RESET_CYCLES = 20 // restart hold length, passed from the core
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic reset_pin_n,
  input wire logic [95:0] dac_code,
  input wire logic [7:0] dac_powerdown,
  input wire logic [7:0] dac_hiz,
  input wire logic ref_enable,
  input wire logic adc_power,
  input wire logic [15:0] conversion_sequence,
  input wire logic [7:0] analog_input_pins,
  input wire logic [7:0] analog_output_pins,
  input wire logic [7:0] pulldown_pins,
  input wire logic restart_busy
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // helper: cycles spent in the current restart
  int busy_cnt;
  always_ff @(posedge clk_sys) begin
    busy_cnt <= (restart_busy && rst_n) ? busy_cnt + 1 : 0;
  end

  // ==========================================================
  // power relations
  a_hiz_follows_pd: assert property (dac_hiz == dac_powerdown)
    else $error("high impedance differs from power-down");
  // a channel that is no analog output only powers down under the global override
  a_pd_scope_only: assert property ((dac_powerdown & ~analog_output_pins) != 8'h00 |-> dac_powerdown == 8'hFF)
    else $error("power-down reached a non-output channel");
  a_global_all_off: assert property (dac_powerdown == 8'hFF && analog_output_pins != 8'hFF |->
    !ref_enable && !adc_power)
    else $error("global power-down left reference or converter on");
  a_adc_auto_off: assert property (analog_input_pins == 8'h00 && !conversion_sequence[pmpr_pkg::TEMP_READ_BIT] |->
    !adc_power)
    else $error("converter powered with no analog input");
  a_adc_wakes_up: assert property ((analog_input_pins != 8'h00 || conversion_sequence[pmpr_pkg::TEMP_READ_BIT]) &&
    dac_powerdown != 8'hFF |-> adc_power)
    else $error("converter stayed off");
  a_code_kept_pd: assert property ($changed(dac_powerdown) && !restart_busy |-> $stable(dac_code))
    else $error("held code lost across power-down");

  // ==========================================================
  // restart relations
  a_restart_defaults: assert property ($rose(restart_busy) |-> pulldown_pins == 8'hFF &&
    conversion_sequence == 16'h0000 && dac_code == '0 && !ref_enable)
    else $error("restart left a register off its default");
  a_restart_length: assert property ($fell(restart_busy) |-> busy_cnt == RESET_CYCLES)
    else $error("restart hold length wrong");
  a_restart_no_ack: assert property (restart_busy |-> !sda_oe)
    else $error("data line pulled during restart");
  a_pin_restarts: assert property ($fell(reset_pin_n) |-> ##[1:16] $rose(restart_busy))
    else $error("reset pin fall started no restart");
  a_open_drain_low: assert property (sda_out == 1'b0)
    else $error("data line driven high");

  c_restart: cover property ($rose(restart_busy));
  c_global: cover property (dac_powerdown == 8'hFF);
  c_reference: cover property (ref_enable);
endmodule // pmpr_core_checker

/* File: tb/pmpr_i2c_ctrl.sv */
// controller model: drives the bus clock and pulls the data line low
// assumes the testbench resolves the open-drain data line with a pull-up
`timescale 1ns/1ps
module pmpr_i2c_ctrl #(
  parameter int HALF = 40, // clock half period in system clocks, well above the core's filter delay
  parameter int SETUP = 8 // data changes this long after the clock falls
) (
  input wire logic clk_sys,
  input wire logic sda_in,
  output logic scl,
  output logic sda_low
);
  // idle bus: clock stands high outside frames, data released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  // one bit, sampled just before the clock falls so the answer has settled
  task automatic bit_x(input logic b, output logic r);
    hold(SETUP);
    sda_low = !b;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    r = sda_in;
    scl = 1'b0;
  endtask
  task automatic byte_out(input logic [7:0] v, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(v[i], r);
    end
    bit_x(1'b1, nak);
  endtask
  // a nack on the last byte ends the read
  task automatic byte_in(output logic [7:0] v, input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, v[i]);
    end
    bit_x(last, r);
  endtask
  task automatic start();
    sda_low = 1'b1;
    hold(HALF);
    scl = 1'b0;
  endtask
  task automatic stop();
    hold(SETUP);
    sda_low = 1'b1;
    hold(HALF);
    scl = 1'b1;
    hold(HALF);
    sda_low = 1'b0;
    hold(HALF);
  endtask
  // write: address, pointer, then one word when two is set; gap keeps the clock still
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [15:0] d, input logic two,
                    input int gap, output logic [3:0] nak);
    nak = 4'hF;
    start();
    byte_out({a, 1'b0}, nak[3]);
    byte_out(p, nak[2]);
    if (two) begin
      byte_out(d[15:8], nak[1]);
      byte_out(d[7:0], nak[0]);
    end
    hold(gap);
    stop();
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] d, output logic nak);
    start();
    byte_out({a, 1'b1}, nak);
    byte_in(d[15:8], 1'b0);
    byte_in(d[7:0], 1'b1);
    stop();
  endtask
endmodule // pmpr_i2c_ctrl

/* File: tb/pmpr_core_test.sv */
// testbench: register writes, power-down, readback modes and both resets
// assumes the package, core, checker and controller model are compiled first
`timescale 1ns/1ps
module pmpr_core_test;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_n = 1'b1; // pin idles high
  logic scl, sda_low, sda_out, sda_oe, ref_enable, adc_power, restart_busy;
  logic [95:0] dac_code;
  logic [7:0] dac_powerdown, dac_hiz, ain, aout, pulls, dsel, dval, dinp, drain, hiz;
  logic [15:0] conversion_sequence, rd_word, gctl, lmode;
  logic [3:0] nak;
  wire sda_line = (sda_oe ? sda_out : 1'b1) & !sda_low; // open drain with pull-up
  int failures = 0;
  int checked = 0;
  always #2 clk_sys = !clk_sys;

  pmpr_core #(.RESET_CYCLES(20)) pmpr_core_i (.clk_sys(clk_sys), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .reset_pin_n(reset_pin_n), .adc_result(16'h1234), .gpio_level(8'hA5),
    .dac_code(dac_code), .dac_powerdown(dac_powerdown), .dac_hiz(dac_hiz), .ref_enable(ref_enable),
    .adc_power(adc_power), .conversion_sequence(conversion_sequence), .general_control(gctl),
    .analog_input_pins(ain), .analog_output_pins(aout), .pulldown_pins(pulls), .load_mode(lmode),
    .digital_output_pins(dsel), .digital_output_value(dval), .digital_input_pins(dinp), .drain_mode_pins(drain),
    .high_impedance_pins(hiz), .restart_busy(restart_busy));
  pmpr_i2c_ctrl pmpr_i2c_ctrl_i (.clk_sys(clk_sys), .sda_in(sda_line), .scl(scl), .sda_low(sda_low));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // full register write, every byte must be acked
  task automatic wr(input logic [7:0] p, input logic [15:0] d);
    pmpr_i2c_ctrl_i.wr(7'h10, p, d, 1'b1, 0, nak);
    check({12'h000, nak}, 16'h0000);
  endtask
  // pointer-only write, then one word read back
  task automatic peek(input logic [7:0] p, input logic [15:0] exp);
    logic n;
    pmpr_i2c_ctrl_i.wr(7'h10, p, 16'h0000, 1'b0, 0, nak);
    pmpr_i2c_ctrl_i.rd(7'h10, rd_word, n);
    check({12'h000, nak[3:2], 1'b0, n}, 16'h0000);
    check(rd_word, exp);
  endtask

  task automatic t_defaults();
    check({8'h00, pulls}, 16'h00FF);
    check(conversion_sequence, 16'h0000);
    check({14'h0000, ref_enable, adc_power}, 16'h0000);
    check({8'h00, dac_powerdown}, 16'h0000);
    check(gctl, 16'h0000);
    check(lmode, 16'h0000);
    check({dsel, dval}, 16'h0000);
    check({dinp, drain}, 16'h0000);
    check({8'h00, hiz}, 16'h0000);
    $display("defaults done");
  endtask
  task automatic t_power();
    wr(8'h05, 16'h000F); // channels 0 to 3 are analog outputs
    wr(8'h11, 16'h0ABC);
    check({4'h0, dac_code[23:12]}, 16'h0ABC);
    wr(8'h0B, 16'h0233); // channels 4 and 5 are no outputs, so stay up
    check({8'h00, dac_powerdown}, 16'h0003);
    check({8'h00, dac_hiz}, 16'h0003);
    check({15'h0000, ref_enable}, 16'h0001);
    wr(8'h0B, 16'h0000);
    check({4'h0, dac_code[23:12]}, 16'h0ABC);
    wr(8'h04, 16'h0080);
    check({15'h0000, adc_power}, 16'h0001);
    wr(8'h0B, 16'h0603); // global override beats the enable bit
    check({8'h00, dac_powerdown}, 16'h00FF);
    check({14'h0000, ref_enable, adc_power}, 16'h0000);
    $display("power-down done");
  endtask
  task automatic t_modes();
    peek(8'h5B, 16'h0603);
    peek(8'h31, 16'h9ABC);
    peek(8'h20, 16'h1234);
    peek(8'h40, 16'h00A5);
    $display("readback modes done");
  endtask
  task automatic t_adc();
    wr(8'h0B, 16'h0000);
    wr(8'h04, 16'h0000);
    check({15'h0000, adc_power}, 16'h0000);
    wr(8'h02, 16'h0100); // temperature read wakes the converter
    check({15'h0000, adc_power}, 16'h0001);
    $display("converter power done");
  endtask
  task automatic t_refuse();
    pmpr_i2c_ctrl_i.wr(7'h11, 8'h04, 16'h00FF, 1'b1, 0, nak);
    check({12'h000, nak}, 16'h000F);
    wr(8'h0D, 16'h00C3); // last register of the map still lands
    check({8'h00, hiz}, 16'h00C3);
    wr(8'h0E, 16'hFFFF);
    wr(8'h0F, 16'h1234); // wrong key must not restart
    wr(8'h7B, 16'hFFFF);
    check({ain, pulls}, 16'h00FF);
    check(conversion_sequence, 16'h0100);
    check({7'h00, restart_busy, dac_powerdown}, 16'h0000);
    $display("refusals done");
  endtask
  task automatic t_restart();
    pmpr_i2c_ctrl_i.wr(7'h10, 8'h0F, 16'h0DAC, 1'b1, 40, nak);
    check({12'h000, nak}, 16'h0001);
    check(conversion_sequence, 16'h0000);
    check({aout, pulls}, 16'h00FF);
    check({drain, hiz}, 16'h0000);
    $display("soft restart done");
  endtask
  task automatic t_pin();
    wr(8'h06, 16'h0000);
    check({8'h00, pulls}, 16'h0000);
    reset_pin_n = 1'b0;
    repeat (10) @(negedge clk_sys);
    check({15'h0000, restart_busy}, 16'h0001);
    reset_pin_n = 1'b1;
    repeat (60) @(negedge clk_sys);
    check({8'h00, pulls}, 16'h00FF);
    $display("reset pin done");
  endtask

  // main sequence, inputs change at the falling edge
  initial begin
    repeat (20) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (10) @(negedge clk_sys);
    t_defaults();
    t_power();
    t_modes();
    t_adc();
    t_refuse();
    t_restart();
    t_pin();
    results();
  end
  // watchdog, past the roughly 71000 cycles the tests need
  initial begin
    repeat (95000) @(posedge clk_sys);
    failures++;
    results();
  end
endmodule // pmpr_core_test

bind pmpr_core pmpr_core_checker #(.RESET_CYCLES(RESET_CYCLES)) pmpr_core_checker_i (.clk_sys(clk_sys),
  .rst_n(rst_n), .sda_out(sda_out), .sda_oe(sda_oe), .reset_pin_n(reset_pin_n), .dac_code(dac_code),
  .dac_powerdown(dac_powerdown), .dac_hiz(dac_hiz), .ref_enable(ref_enable), .adc_power(adc_power),
  .conversion_sequence(conversion_sequence), .analog_input_pins(analog_input_pins),
  .analog_output_pins(analog_output_pins), .pulldown_pins(pulldown_pins), .restart_busy(restart_busy));
